// *** rtl/ccp_pkg.sv ***
// Constants, types and register map of the capture/compare/PWM unit
package ccp_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_CAPSEL  = 2'h1;
    localparam logic [1:0] ADDR_LOW     = 2'h2;
    localparam logic [1:0] ADDR_HIGH    = 2'h3;

    localparam int CTRL_EN_BIT  = 7;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_RSV_BIT = 6;
    localparam int CTRL_FMT_BIT = 4;
    localparam int CAPSEL_W     = 3;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] MODE_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Mode field
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_OFF           = 4'h0;
    localparam logic [3:0] MODE_CMP_TGL_CLR   = 4'h1;
    localparam logic [3:0] MODE_CMP_TGL       = 4'h2;
    localparam logic [3:0] MODE_CAP_EVERY     = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL      = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE      = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4     = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16    = 4'h7;
    localparam logic [3:0] MODE_CMP_SET       = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR     = 4'h9;
    localparam logic [3:0] MODE_CMP_PULSE     = 4'ha;
    localparam logic [3:0] MODE_CMP_PULSE_CLR = 4'hb;
    localparam logic [3:0] MODE_RSVD_FIRST    = 4'hc;
    localparam logic [3:0] MODE_PWM           = 4'hf;

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    localparam logic [3:0] PRESCALE_4_LAST  = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hf;
    // Period timer steps once per four system clocks
    localparam logic [1:0] PHASE_LAST = 2'h3;

    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b01,
        PULSE_HIGH = 2'b10
    } pulse_state_t;

endpackage

// *** rtl/edge_sync.sv ***
// Two-stage input synchroniser with rising and falling edge detect
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control and data
    input  wire logic run,
    input  wire logic data_in,
    // Edges
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic meta_d;
    logic sync_d;
    logic prev_d;

    always_comb begin
        meta_d = run ? data_in : meta_q;
        sync_d = run ? meta_q  : sync_q;
        prev_d = run ? sync_q  : prev_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign rise = run && sync_q && !prev_q;
    assign fall = run && !sync_q && prev_q;
endmodule // edge_sync
`default_nettype wire

// *** rtl/capture_compare_pwm_unit.sv ***
// Capture/compare/PWM unit with byte-wide register port
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_pwm_unit (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata_q,
    // Power state
    input  wire logic        sleep,
    // Timers
    input  wire logic [15:0] sixteen_bit_timer,
    output logic             timer_clear_q,
    input  wire logic [7:0]  period_limit,
    output logic      [7:0]  period_timer_q,
    // Capture sources
    input  wire logic        remapped_input_pin,
    input  wire logic        comparator_one_output,
    input  wire logic        comparator_two_output,
    input  wire logic        pin_change_event,
    input  wire logic [3:0]  logic_cell_output,
    // Output pin
    output logic             ccp_pin_out_q,
    output logic             ccp_pin_oe_q,
    // Events
    output logic             unit_interrupt_flag_q,
    input  wire logic        adc_trigger_selected,
    output logic             adc_trigger_q
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                  ctrl_en_q, ctrl_en_d;
    logic                  pulse_width_alignment_q, pulse_width_alignment_d;
    logic [3:0]            mode_q, mode_d;
    logic [ccp_pkg::CAPSEL_W-1:0] capsel_q, capsel_d;
    logic [7:0]            match_value_low_q, match_value_low_d;
    logic [7:0]            match_value_high_q, match_value_high_d;
    logic [3:0]            prescale_q, prescale_d;
    logic [1:0]            phase_q, phase_d;
    logic [7:0]            period_timer_d;
    logic [9:0]            duty_buf_q, duty_buf_d;
    logic                  match_prev_q, match_prev_d;
    ccp_pkg::pulse_state_t pulse_q, pulse_d;
    logic                  out_d, oe_d, event_d, adc_d, tclr_d;
    logic [7:0]            rdata_d;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic       run, active, is_capture, is_pwm, is_compare;
    logic       cap_rise, cap_fall, cap_edge, cmp_level, cmp_hit;
    logic       step, wrap, hw_event;
    logic [7:0] cap_sources;
    logic [9:0] duty, timebase, timebase_next;

    assign run = !sleep;
    assign active = ctrl_en_q && (mode_q != ccp_pkg::MODE_OFF);
    assign is_capture = active && (mode_q >= ccp_pkg::MODE_CAP_EVERY)
                        && (mode_q <= ccp_pkg::MODE_CAP_RISE16);
    assign is_pwm = active && (mode_q == ccp_pkg::MODE_PWM);
    // Reserved codes leave the unit idle
    assign is_compare = active && !is_capture && !is_pwm
                        && (mode_q < ccp_pkg::MODE_RSVD_FIRST);

    assign cap_sources = {logic_cell_output, pin_change_event,
                          comparator_two_output, comparator_one_output,
                          remapped_input_pin};

    edge_sync u_edge_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (run),
        .data_in (cap_sources[capsel_q]),
        .rise    (cap_rise),
        .fall    (cap_fall)
    );

    always_comb begin
        cap_edge = 1'b0;
        if (is_capture) begin
            case (mode_q)
                ccp_pkg::MODE_CAP_EVERY:  cap_edge = cap_rise || cap_fall;
                ccp_pkg::MODE_CAP_FALL:   cap_edge = cap_fall;
                ccp_pkg::MODE_CAP_RISE:   cap_edge = cap_rise;
                ccp_pkg::MODE_CAP_RISE4:  cap_edge = cap_rise
                    && (prescale_q == ccp_pkg::PRESCALE_4_LAST);
                ccp_pkg::MODE_CAP_RISE16: cap_edge = cap_rise
                    && (prescale_q == ccp_pkg::PRESCALE_16_LAST);
                default:                  cap_edge = 1'b0;
            endcase
        end
    end

    assign cmp_level = is_compare && (sixteen_bit_timer
                       == {match_value_high_q, match_value_low_q});
    // Act on the first cycle of a match only, so a slow timer
    // holding the value does not toggle repeatedly
    assign cmp_hit = cmp_level && !match_prev_q;

    assign duty = pulse_width_alignment_q
                ? {match_value_high_q, match_value_low_q[7:6]}
                : {match_value_high_q[1:0], match_value_low_q};
    // time base from timer and clock phase
    assign timebase = {period_timer_q, phase_q};
    assign timebase_next = 10'(timebase + 10'h001);
    assign step = is_pwm && (phase_q == ccp_pkg::PHASE_LAST);
    assign wrap = step && (period_timer_q == period_limit);
    assign hw_event = cap_edge || cmp_hit || wrap;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_en_d               = ctrl_en_q;
        pulse_width_alignment_d = pulse_width_alignment_q;
        mode_d                  = mode_q;
        capsel_d                = capsel_q;
        match_value_low_d       = match_value_low_q;
        match_value_high_d      = match_value_high_q;
        prescale_d              = prescale_q;
        phase_d                 = phase_q;
        period_timer_d          = period_timer_q;
        duty_buf_d              = duty_buf_q;
        match_prev_d            = match_prev_q;
        pulse_d                 = pulse_q;
        out_d                   = ccp_pin_out_q;
        event_d                 = 1'b0;
        tclr_d                  = 1'b0;
        rdata_d                 = ccp_pkg::BYTE_RESET;

        // Software writes; hardware updates below win
        if (reg_write) begin
            if (reg_addr == ccp_pkg::ADDR_CONTROL) begin
                ctrl_en_d = reg_wdata[ccp_pkg::CTRL_EN_BIT];
                pulse_width_alignment_d = reg_wdata[ccp_pkg::CTRL_FMT_BIT];
                mode_d = reg_wdata[3:0];
            end else if (reg_addr == ccp_pkg::ADDR_CAPSEL) begin
                capsel_d = reg_wdata[ccp_pkg::CAPSEL_W-1:0];
            end else if (reg_addr == ccp_pkg::ADDR_LOW) begin
                match_value_low_d = reg_wdata;
            end else begin
                match_value_high_d = reg_wdata;
            end
        end

        if (run) begin
            if (!active) begin
                prescale_d     = ccp_pkg::MODE_RESET;
                phase_d        = ccp_pkg::PHASE_LAST - ccp_pkg::PHASE_LAST;
                period_timer_d = ccp_pkg::BYTE_RESET;
                match_prev_d   = 1'b0;
                pulse_d        = ccp_pkg::PULSE_IDLE;
                out_d          = 1'b0;
            end else begin
                if (cap_rise && (mode_q == ccp_pkg::MODE_CAP_RISE4
                    || mode_q == ccp_pkg::MODE_CAP_RISE16)) begin
                    prescale_d = cap_edge ? ccp_pkg::MODE_RESET
                               : 4'(prescale_q + 4'h1);
                end
                if (cap_edge) begin
                    match_value_low_d  = sixteen_bit_timer[7:0];
                    match_value_high_d = sixteen_bit_timer[15:8];
                end

                match_prev_d = cmp_level;
                if (pulse_q == ccp_pkg::PULSE_HIGH) begin
                    out_d   = 1'b0;
                    pulse_d = ccp_pkg::PULSE_IDLE;
                end
                if (cmp_hit) begin
                    case (mode_q)
                        ccp_pkg::MODE_CMP_SET:   out_d = 1'b1;
                        ccp_pkg::MODE_CMP_CLEAR: out_d = 1'b0;
                        ccp_pkg::MODE_CMP_PULSE,
                        ccp_pkg::MODE_CMP_PULSE_CLR: begin
                            out_d   = 1'b1;
                            pulse_d = ccp_pkg::PULSE_HIGH;
                        end
                        default: out_d = !ccp_pin_out_q;
                    endcase
                    tclr_d = (mode_q == ccp_pkg::MODE_CMP_TGL_CLR)
                          || (mode_q == ccp_pkg::MODE_CMP_PULSE_CLR);
                end

                if (is_pwm) begin
                    phase_d = 2'(phase_q + 2'h1);
                    // end of pulse; the pin is registered, so it is
                    // cleared one clock ahead to be low at the equal count
                    if (timebase == duty_buf_q
                        || timebase_next == duty_buf_q) begin
                        out_d = 1'b0;
                    end
                    if (wrap) begin
                        period_timer_d = ccp_pkg::BYTE_RESET;
                        duty_buf_d     = duty;
                        out_d          = (duty != 10'h000);
                    end else if (step) begin
                        period_timer_d = 8'(period_timer_q + 8'h01);
                    end
                end
                event_d = hw_event;
            end
        end

        adc_d = event_d && adc_trigger_selected;
        // driver on only for output modes
        oe_d = ctrl_en_q && (is_compare || is_pwm);

        if (reg_read) begin
            if (reg_addr == ccp_pkg::ADDR_CONTROL) begin
                rdata_d[ccp_pkg::CTRL_EN_BIT]  = ctrl_en_q;
                rdata_d[ccp_pkg::CTRL_OUT_BIT] = ccp_pin_out_q;
                rdata_d[ccp_pkg::CTRL_FMT_BIT] = pulse_width_alignment_q;
                rdata_d[3:0]                   = mode_q;
            end else if (reg_addr == ccp_pkg::ADDR_CAPSEL) begin
                rdata_d[ccp_pkg::CAPSEL_W-1:0] = capsel_q;
            end else if (reg_addr == ccp_pkg::ADDR_LOW) begin
                rdata_d = match_value_low_q;
            end else begin
                rdata_d = match_value_high_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // reset to defaults, pin as input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_en_q               <= 1'b0;
            pulse_width_alignment_q <= 1'b0;
            mode_q                  <= ccp_pkg::MODE_RESET;
            capsel_q                <= '0;
            match_value_low_q       <= ccp_pkg::BYTE_RESET;
            match_value_high_q      <= ccp_pkg::BYTE_RESET;
            prescale_q              <= ccp_pkg::MODE_RESET;
            phase_q                 <= '0;
            period_timer_q          <= ccp_pkg::BYTE_RESET;
            duty_buf_q              <= '0;
            match_prev_q            <= 1'b0;
            pulse_q                 <= ccp_pkg::PULSE_IDLE;
            ccp_pin_out_q           <= 1'b0;
            ccp_pin_oe_q            <= 1'b0;
            unit_interrupt_flag_q   <= 1'b0;
            adc_trigger_q           <= 1'b0;
            timer_clear_q           <= 1'b0;
            reg_rdata_q             <= ccp_pkg::BYTE_RESET;
        end else begin
            ctrl_en_q               <= ctrl_en_d;
            pulse_width_alignment_q <= pulse_width_alignment_d;
            mode_q                  <= mode_d;
            capsel_q                <= capsel_d;
            match_value_low_q       <= match_value_low_d;
            match_value_high_q      <= match_value_high_d;
            prescale_q              <= prescale_d;
            phase_q                 <= phase_d;
            period_timer_q          <= period_timer_d;
            duty_buf_q              <= duty_buf_d;
            match_prev_q            <= match_prev_d;
            pulse_q                 <= pulse_d;
            ccp_pin_out_q           <= out_d;
            ccp_pin_oe_q            <= oe_d;
            unit_interrupt_flag_q   <= event_d;
            adc_trigger_q           <= adc_d;
            timer_clear_q           <= tclr_d;
            reg_rdata_q             <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_pulse_hit;
        cmp_hit && run && (mode_q == ccp_pkg::MODE_CMP_PULSE
                        || mode_q == ccp_pkg::MODE_CMP_PULSE_CLR);
    endsequence
    sequence s_pulse_shape;
        ccp_pin_out_q ##1 !ccp_pin_out_q;
    endsequence

    AST_SLEEP_FREEZE: assert property (
        sleep |=> $stable(period_timer_q) && $stable(phase_q))
        else $error("period timer moved during sleep");
    AST_SLEEP_PIN: assert property (
        sleep |=> $stable(ccp_pin_out_q))
        else $error("pin changed during sleep");
    AST_RESUME_COUNT: assert property (
        run && step && !wrap
        |=> period_timer_q == 8'($past(period_timer_q) + 8'h01))
        else $error("period timer did not advance by one");
    AST_DISABLED_INPUT: assert property (
        !ctrl_en_q |=> !ccp_pin_oe_q)
        else $error("pin driven while unit disabled");
    AST_OUT_READBACK: assert property (
        reg_read && reg_addr == ccp_pkg::ADDR_CONTROL
        |=> reg_rdata_q[ccp_pkg::CTRL_OUT_BIT] == $past(ccp_pin_out_q))
        else $error("output bit read-back wrong");
    AST_CMP_SET: assert property (
        cmp_hit && run && mode_q == ccp_pkg::MODE_CMP_SET
        |=> ccp_pin_out_q)
        else $error("set on match failed");
    AST_CMP_PULSE: assert property (
        s_pulse_hit ##1 run |-> s_pulse_shape)
        else $error("match pulse shape wrong");
    AST_CMP_TOGGLE: assert property (
        cmp_hit && run && mode_q == ccp_pkg::MODE_CMP_TGL
        |=> ccp_pin_out_q != $past(ccp_pin_out_q))
        else $error("toggle on match failed");
    AST_TIMER_CLEAR: assert property (
        cmp_hit && run && (mode_q == ccp_pkg::MODE_CMP_TGL_CLR
                        || mode_q == ccp_pkg::MODE_CMP_PULSE_CLR)
        |=> timer_clear_q ##1 !timer_clear_q)
        else $error("timer clear pulse missing");
    AST_EVENT_FLAG: assert property (
        run && active && hw_event |=> unit_interrupt_flag_q)
        else $error("event flag not raised");
    AST_RSVD_READ: assert property (
        reg_read && reg_addr == ccp_pkg::ADDR_CONTROL
        |=> reg_rdata_q[ccp_pkg::CTRL_RSV_BIT] == 1'b0)
        else $error("unimplemented bit read as one");
    AST_CAPSEL_READ: assert property (
        reg_read && reg_addr == ccp_pkg::ADDR_CAPSEL
        |=> (reg_rdata_q >> ccp_pkg::CAPSEL_W) == 8'h00)
        else $error("unimplemented source bits read as one");
    AST_PWM_END: assert property (
        run && is_pwm && !wrap && timebase == duty_buf_q
        |=> !ccp_pin_out_q)
        else $error("pwm output not cleared at duty");
endmodule // capture_compare_pwm_unit
`default_nettype wire

// *** test/capture_compare_pwm_unit_tb.sv ***
// Self-checking testbench of the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none
module capture_compare_pwm_unit_tb;
    logic        clk;
    logic        reset_n;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_rdata_q;
    logic        sleep;
    logic [15:0] tmr;
    logic        tclr;
    logic [7:0]  period_limit;
    logic [7:0]  period_timer_q;
    logic [7:0]  srcv;
    logic        pin;
    logic        oe;
    logic        flag;
    logic        adc_sel;
    logic        adc;
    logic        rd_d = 1'b0;
    logic [7:0]  q[$];
    logic [15:0] r;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          n_flag = 0;
    int          n_adc = 0;
    int          n_clr = 0;
    int          c0;
    int          c1;
    int          hi;
    int          mx;

    capture_compare_pwm_unit DUT (.clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata_q, .sleep,
        .sixteen_bit_timer(tmr), .timer_clear_q(tclr), .period_limit,
        .period_timer_q, .remapped_input_pin(srcv[0]),
        .comparator_one_output(srcv[1]), .comparator_two_output(srcv[2]),
        .pin_change_event(srcv[3]), .logic_cell_output(srcv[7:4]),
        .ccp_pin_out_q(pin), .ccp_pin_oe_q(oe),
        .unit_interrupt_flag_q(flag), .adc_trigger_selected(adc_sel),
        .adc_trigger_q(adc));

    // ------------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------------
    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Bus master and monitors
    // ------------------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        q.push_back(exp);
        @(posedge clk);
        reg_read <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) check_rd(reg_rdata_q, q.pop_front());
        rd_d <= reg_read;
        if (flag) n_flag++;
        if (adc) n_adc++;
        if (tclr) n_clr++;
    end

    task automatic pwm_count;
        repeat (40) @(posedge clk);
        hi = 0;
        mx = 0;
        repeat (64) begin
            @(posedge clk);
            hi += int'(pin);
            if (int'(period_timer_q) > mx) mx = int'(period_timer_q);
        end
        check_val(hi[15:0], 16'h0020);
        check_val(mx[15:0], 16'h0003);
    endtask

    // Pulses last long enough to pass both sync stages
    task automatic edges(input int n);
        repeat (n) begin
            srcv <= 8'h01;
            repeat (4) @(posedge clk);
            srcv <= 8'h00;
            repeat (6) @(posedge clk);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        // About thirteen times the expected run
        #200000;
        n_mismatch++;
        final_report;
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {reset_n, reg_write, reg_read, sleep, adc_sel} = '0;
        {reg_addr, reg_wdata, tmr, period_limit, srcv} = '0;
        void'($urandom(21));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
        check_val({15'h0, oe}, 16'h0000);
        wr(2'h0, 8'h7f);
        wr(2'h1, 8'hff);
        rd(2'h0, 8'h1f);
        rd(2'h1, 8'h07);
        $display("test registers done");
        adc_sel <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(2'h0, 8'h00);
            wr(2'h1, i[7:0]);
            r = 16'($urandom);
            tmr <= r;
            wr(2'h0, 8'h85);
            srcv <= 8'h01 << i;
            repeat (8) @(posedge clk);
            rd(2'h2, r[7:0]);
            rd(2'h3, r[15:8]);
            srcv <= 8'h00;
        end
        check_val(n_flag[15:0], 16'h0008);
        check_val(n_adc[15:0], 16'h0008);
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h83);
        adc_sel <= 1'b0;
        c0 = n_flag;
        c1 = n_adc;
        edges(1);
        check_val(16'(n_flag - c0), 16'h0002);
        check_val(16'(n_adc - c1), 16'h0000);
        adc_sel <= 1'b1;
        wr(2'h0, 8'h84);
        c0 = n_flag;
        edges(1);
        check_val(16'(n_flag - c0), 16'h0001);
        wr(2'h0, 8'h86);
        c0 = n_flag;
        edges(2);
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h86);
        edges(3);
        check_val(16'(n_flag - c0), 16'h0000);
        edges(1);
        check_val(16'(n_flag - c0), 16'h0001);
        wr(2'h0, 8'h87);
        edges(15);
        check_val(16'(n_flag - c0), 16'h0001);
        edges(1);
        check_val(16'(n_flag - c0), 16'h0002);
        $display("test capture done");
        tmr <= 16'h0000;
        wr(2'h2, 8'h34);
        wr(2'h3, 8'h12);
        wr(2'h0, 8'h88);
        tmr <= 16'h1234;
        repeat (3) @(posedge clk);
        rd(2'h0, 8'ha8);
        check_val({15'h0, oe}, 16'h0001);
        tmr <= 16'h0000;
        wr(2'h0, 8'h89);
        tmr <= 16'h1234;
        repeat (3) @(posedge clk);
        rd(2'h0, 8'h89);
        wr(2'h0, 8'h00);
        tmr <= 16'h0000;
        c0 = n_clr;
        wr(2'h0, 8'h81);
        tmr <= 16'h1234;
        repeat (3) @(posedge clk);
        rd(2'h0, 8'ha1);
        tmr <= 16'h0000;
        wr(2'h0, 8'h8b);
        tmr <= 16'h1234;
        repeat (4) @(posedge clk);
        rd(2'h0, 8'h8b);
        check_val(16'(n_clr - c0), 16'h0002);
        tmr <= 16'h0000;
        c0 = n_clr;
        wr(2'h0, 8'h00);
        wr(2'h0, 8'h82);
        tmr <= 16'h1234;
        repeat (3) @(posedge clk);
        rd(2'h0, 8'ha2);
        tmr <= 16'h0000;
        repeat (2) @(posedge clk);
        tmr <= 16'h1234;
        repeat (3) @(posedge clk);
        rd(2'h0, 8'h82);
        tmr <= 16'h0000;
        wr(2'h0, 8'h8a);
        tmr <= 16'h1234;
        repeat (2) @(posedge clk);
        check_val({15'h0, pin}, 16'h0001);
        @(posedge clk);
        check_val({15'h0, pin}, 16'h0000);
        check_val(16'(n_clr - c0), 16'h0000);
        $display("test compare done");
        period_limit <= 8'h03;
        wr(2'h2, 8'h08);
        wr(2'h3, 8'hfc);
        wr(2'h0, 8'h8f);
        pwm_count();
        wr(2'h3, 8'h02);
        wr(2'h2, 8'h3f);
        wr(2'h0, 8'h9f);
        pwm_count();
        @(posedge clk);
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        r = {period_timer_q, 7'h00, pin};
        repeat (20) @(posedge clk);
        check_val({period_timer_q, 7'h00, pin}, r);
        sleep <= 1'b0;
        $display("test pwm and sleep done");
        wr(2'h0, 8'h80);
        repeat (2) @(posedge clk);
        check_val({14'h0, oe, pin}, 16'h0000);
        $display("test off done");
        wr(2'h0, 8'h8f);
        repeat (20) @(posedge clk);
        check_val({15'h0, oe}, 16'h0001);
        reset_n <= 1'b0;
        @(posedge clk);
        check_val({14'h0, oe, flag}, 16'h0000);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00);
        $display("test reset done");
        final_report;
    end
endmodule // capture_compare_pwm_unit_tb
`default_nettype wire
